// ===== tec_edge_det.sv
`timescale 1ns/10ps
module tec_edge_det
    import tec_pkg::*;
(
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire logic      pin,
    output tec_edge_t      edges
);
    logic [2:0] sync_ff;
    logic       level_ff;
    tec_edge_t  edges_ff;
    wire        agree = sync_ff[1] == sync_ff[2];

    // a change counts only once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_ff  <= 3'h0;
            level_ff <= 1'b0;
            edges_ff <= '0;
        end else begin
            sync_ff  <= {sync_ff[1:0], pin};
            level_ff <= agree ? sync_ff[2] : level_ff;
            edges_ff <= '{rise: agree & sync_ff[2] & ~level_ff,
                          fall: agree & ~sync_ff[2] & level_ff};
        end
    end

    assign edges = edges_ff;
endmodule

// ===== tec_pkg.sv
package tec_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int          TEC_ADDR_W     = 12;
    localparam logic [31:0] TEC_CTL0_IDX   = 32'hFFFF5590;
    localparam logic [31:0] TEC_CTL1_IDX   = 32'hFFFFF591;
    localparam logic [11:0] TEC_CTL0_ADDR  = {TEC_CTL0_IDX[9:0], 2'b00};
    localparam logic [11:0] TEC_CTL1_ADDR  = {TEC_CTL1_IDX[9:0], 2'b00};
    localparam logic [11:0] TEC_CCR0_ADDR  = 12'h650;
    localparam logic [11:0] TEC_CCR1_ADDR  = 12'h654;
    localparam logic [11:0] TEC_CNT_ADDR   = 12'h658;
    localparam logic [11:0] TEC_OUTC_ADDR  = 12'h65C;
    localparam logic [11:0] TEC_CAPE_ADDR  = 12'h660;
    localparam logic [11:0] TEC_EVTE_ADDR  = 12'h664;
    localparam logic [11:0] TEC_STAT_ADDR  = 12'h668;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int TEC_CTL0_RUN_BIT  = 7;
    localparam int TEC_CTL0_CKS_MSB  = 2;
    localparam int TEC_CTL1_SYNC_BIT = 7;
    localparam int TEC_CTL1_TRIG_BIT = 6;
    localparam int TEC_CTL1_EEE_BIT  = 5;
    localparam int TEC_CTL1_MD_MSB   = 2;
    localparam int TEC_STAT_OVF_BIT  = 0;

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0]  TEC_CTL_RST    = 8'h00;
    localparam logic [3:0]  TEC_IOC_RST    = 4'h0;
    localparam logic [15:0] TEC_CCR_RST    = 16'h0000;
    localparam logic [15:0] TEC_CNT_IDLE   = 16'hFFFF;
    localparam logic [15:0] TEC_CNT_RD_OFF = 16'h0000;
    localparam int          TEC_PRE_W      = 7;
    localparam logic [2:0]  TEC_CKS_SUB    = 3'h7;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TEC_INTERVAL, TEC_EVENT, TEC_EXT_TRIG, TEC_ONE_SHOT,
        TEC_PWM, TEC_FREE_RUN, TEC_PULSE_MEAS, TEC_PROHIBITED
    } tec_mode_t;

    typedef struct packed {
        logic       run_enable;
        logic [3:0] zero;
        logic [2:0] clk_sel;
    } tec_ctl0_t;

    typedef struct packed {
        logic       slave_sync_enable;
        logic       software_trigger;
        logic       external_event_select;
        logic [1:0] zero;
        logic [2:0] mode_sel;
    } tec_ctl1_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } tec_edge_t;

    // cfg 00 none, 01 rising, 10 falling, 11 both
    function automatic logic tec_edge_ok(input logic [1:0] cfg, input tec_edge_t e);
        return (cfg[0] & e.rise) | (cfg[1] & e.fall);
    endfunction

endpackage

// ===== tec_timer_ctrl.sv
// Design decision made here: register access over APB.
`timescale 1ns/10ps
module tec_timer_ctrl
    import tec_pkg::*;
#(
    parameter int CHANNEL = 0
)
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [TEC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  timer_input_0,
    input  wire logic                  timer_input_1,
    input  wire logic                  subclock,
    input  wire logic                  master_clear,
    output logic                       sync_clear,
    output logic                       compare_match_irq_0,
    output logic                       compare_match_irq_1,
    output logic                       timer_output_0,
    output logic                       timer_output_1
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    tec_ctl0_t              ctl0_ff;
    tec_ctl1_t              ctl1_ff;
    logic [3:0]             outc_ff;
    logic [3:0]             cape_ff;
    logic [3:0]             evte_ff;
    logic [15:0]            cnt_ff;
    logic [TEC_PRE_W-1:0]   pre_ff;
    logic                   armed_ff;
    logic                   started_ff;
    logic                   ovf_ff;
    logic                   sync_ff;
    logic [31:0]            prdata_ff;
    logic [15:0]            ccr_ff [2];
    logic [15:0]            buf_ff [2];
    logic [1:0]             irq_ff;
    logic [1:0]             tstate_ff;
    logic [1:0]             tout_ff;
    tec_edge_t              in_edge [2];
    tec_edge_t              sub_edge;

    // ------------------------------------------------------------------
    // pin edge detection
    // ------------------------------------------------------------------
    tec_edge_det u_in0 (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (timer_input_0),
        .edges   (in_edge[0])
    );
    tec_edge_det u_in1 (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (timer_input_1),
        .edges   (in_edge[1])
    );
    // sampled by pclk, so a stopped main clock also stops subclock counting
    tec_edge_det u_sub (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (subclock),
        .edges   (sub_edge)
    );

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire hit_ctl0 = paddr == TEC_CTL0_ADDR;
    wire hit_ctl1 = paddr == TEC_CTL1_ADDR;
    wire hit_ccr0 = paddr == TEC_CCR0_ADDR;
    wire hit_ccr1 = paddr == TEC_CCR1_ADDR;
    wire hit_cnt  = paddr == TEC_CNT_ADDR;
    wire hit_outc = paddr == TEC_OUTC_ADDR;
    wire hit_cape = paddr == TEC_CAPE_ADDR;
    wire hit_evte = paddr == TEC_EVTE_ADDR;
    wire hit_stat = paddr == TEC_STAT_ADDR;
    wire mapped   = hit_ctl0 | hit_ctl1 | hit_ccr0 | hit_ccr1 | hit_cnt |
                    hit_outc | hit_cape | hit_evte | hit_stat;
    wire wr       = psel & penable & pwrite & mapped;
    wire rd_setup = psel & ~penable & ~pwrite;

    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~mapped;

    // ------------------------------------------------------------------
    // count clock selection
    // ------------------------------------------------------------------
    wire            run       = ctl0_ff.run_enable;
    tec_mode_t      mode;
    assign mode = tec_mode_t'(ctl1_ff.mode_sel);
    wire [TEC_PRE_W-1:0] pre_mask = TEC_PRE_W'((8'h01 << ctl0_ff.clk_sel) - 8'h01);
    wire            odd_chan  = CHANNEL % 2 == 1;
    wire            use_sub   = odd_chan && ctl0_ff.clk_sel == TEC_CKS_SUB;
    wire            int_tick  = use_sub ? sub_edge.rise
                                        : (pre_ff & pre_mask) == pre_mask;
    wire            ext_evt   = tec_edge_ok(evte_ff[3:2], in_edge[0]);
    wire            ext_trg   = tec_edge_ok(evte_ff[1:0], in_edge[0]);
    wire            use_evt   = ctl1_ff.external_event_select | mode == TEC_EVENT;
    wire            trig_mode = mode == TEC_EXT_TRIG || mode == TEC_ONE_SHOT;
    wire            counting  = trig_mode ? armed_ff : 1'b1;
    wire            cnt_tick  = run & counting & (use_evt ? ext_evt : int_tick);
    wire            cmp_mode  = mode != TEC_PULSE_MEAS;
    wire            clr_mode  = mode <= TEC_PWM;
    wire            pwm_type  = mode == TEC_EXT_TRIG || mode == TEC_ONE_SHOT || mode == TEC_PWM;

    // only the two trigger modes honour a written trigger bit
    wire sw_trig = wr & hit_ctl1 & pwdata[TEC_CTL1_TRIG_BIT];
    wire trig    = run & trig_mode & (sw_trig | ext_trg);
    wire slv_clr = run & ctl1_ff.slave_sync_enable & master_clear;

    wire [1:0] match;
    wire       clr_at_0 = match[0] & clr_mode;

    // ------------------------------------------------------------------
    // 16-bit counter
    // ------------------------------------------------------------------
    logic [15:0] nxt_cnt;
    always_comb begin
        nxt_cnt = cnt_ff;
        if (!run) begin
            nxt_cnt = TEC_CNT_IDLE;
        end else if (trig || slv_clr) begin
            nxt_cnt = 16'h0000;
        end else if (cnt_tick) begin
            if (clr_at_0 && mode == TEC_ONE_SHOT) begin
                nxt_cnt = TEC_CNT_IDLE;
            end else if (clr_at_0) begin
                nxt_cnt = 16'h0000;
            end else begin
                nxt_cnt = cnt_ff + 16'h0001;
            end
        end
    end

    wire ovf_set = cnt_tick & started_ff & ~clr_at_0 & cnt_ff == TEC_CNT_IDLE;
    wire ovf_clr = wr & hit_stat & pwdata[TEC_STAT_OVF_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff     <= TEC_CNT_IDLE;
            pre_ff     <= '0;
            started_ff <= 1'b0;
            armed_ff   <= 1'b0;
            ovf_ff     <= 1'b0;
            sync_ff    <= 1'b0;
        end else begin
            cnt_ff     <= nxt_cnt;
            pre_ff     <= run ? pre_ff + 1'b1 : '0;
            started_ff <= run & (started_ff | cnt_tick);
            armed_ff   <= run & (trig | (armed_ff & ~(cnt_tick & clr_at_0 & mode == TEC_ONE_SHOT)));
            // set wins over a clear in the same cycle
            ovf_ff     <= run & (ovf_set | (ovf_ff & ~ovf_clr));
            sync_ff    <= run & (trig | (cnt_tick & clr_at_0));
        end
    end
    assign sync_clear = sync_ff;

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    // reserved bits are stored as zero whatever software writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl0_ff <= TEC_CTL_RST;
            ctl1_ff <= TEC_CTL_RST;
            outc_ff <= TEC_IOC_RST;
            cape_ff <= TEC_IOC_RST;
            evte_ff <= TEC_IOC_RST;
        end else begin
            if (wr && hit_ctl0) begin
                ctl0_ff <= '{run_enable: pwdata[TEC_CTL0_RUN_BIT], zero: 4'h0,
                             clk_sel: pwdata[TEC_CTL0_CKS_MSB:0]};
            end
            if (wr && hit_ctl1) begin
                ctl1_ff <= '{slave_sync_enable: pwdata[TEC_CTL1_SYNC_BIT], software_trigger: 1'b0,
                             external_event_select: pwdata[TEC_CTL1_EEE_BIT], zero: 2'h0,
                             mode_sel: pwdata[TEC_CTL1_MD_MSB:0]};
            end
            if (wr && hit_outc) begin
                outc_ff <= pwdata[3:0];
            end
            if (wr && hit_cape) begin
                cape_ff <= pwdata[3:0];
            end
            if (wr && hit_evte) begin
                evte_ff <= pwdata[3:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // compare channels and output controller
    // ------------------------------------------------------------------
    for (genvar m = 0; m < 2; m++) begin : g_ch
        wire hit_ccr = m == 0 ? hit_ccr0 : hit_ccr1;
        wire cap     = run & mode == TEC_PULSE_MEAS & tec_edge_ok(cape_ff[2*m+1 -: 2], in_edge[m]);
        wire ol      = outc_ff[2*m+1];
        wire oe      = outc_ff[2*m];
        assign match[m] = cnt_tick & cmp_mode & cnt_ff == buf_ff[m];

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ccr_ff[m] <= TEC_CCR_RST;
                buf_ff[m] <= TEC_CCR_RST;
            end else if (cap) begin
                ccr_ff[m] <= cnt_ff;
            end else if (wr && hit_ccr) begin
                ccr_ff[m] <= pwdata[15:0];
                buf_ff[m] <= cmp_mode ? pwdata[15:0] : buf_ff[m];
            end
        end

        logic nxt_tstate;
        always_comb begin
            nxt_tstate = tstate_ff[m];
            if (!run) begin
                nxt_tstate = 1'b0;
            end else if (pwm_type && m == 1) begin
                nxt_tstate = match[1] ? 1'b1 : (clr_at_0 ? 1'b0 : tstate_ff[m]);
            end else if (match[m]) begin
                nxt_tstate = ~tstate_ff[m];
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                irq_ff[m]    <= 1'b0;
                tstate_ff[m] <= 1'b0;
                tout_ff[m]   <= 1'b0;
            end else begin
                irq_ff[m]    <= match[m];
                tstate_ff[m] <= nxt_tstate;
                tout_ff[m]   <= oe ? nxt_tstate ^ ol : ol;
            end
        end
    end

    assign compare_match_irq_0 = irq_ff[0];
    assign compare_match_irq_1 = irq_ff[1];
    assign timer_output_0      = tout_ff[0];
    assign timer_output_1      = tout_ff[1];

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    wire [15:0] cnt_view = run ? cnt_ff : TEC_CNT_RD_OFF;
    wire [31:0] rd_mux   = hit_ctl0 ? {24'h0, ctl0_ff} :
                           hit_ctl1 ? {24'h0, ctl1_ff} :
                           hit_ccr0 ? {16'h0, ccr_ff[0]} :
                           hit_ccr1 ? {16'h0, ccr_ff[1]} :
                           hit_cnt  ? {16'h0, cnt_view} :
                           hit_outc ? {28'h0, outc_ff} :
                           hit_cape ? {28'h0, cape_ff} :
                           hit_evte ? {28'h0, evte_ff} :
                           hit_stat ? {31'h0, ovf_ff} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
        end else if (rd_setup) begin
            prdata_ff <= rd_mux;
        end
    end
    assign prdata = prdata_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_sw_start;
        wr && hit_ctl1 && pwdata[TEC_CTL1_TRIG_BIT] && run && trig_mode && !slv_clr;
    endsequence
    sequence s_started;
        armed_ff && cnt_ff == 16'h0000;
    endsequence

    AST_STOP_HOLDS: assert property (!run |=> cnt_ff == TEC_CNT_IDLE && !ovf_ff)
        else $error("counter or overflow not held while stopped");
    AST_STOP_PINS: assert property (!run ##1 !run |-> timer_output_0 == outc_ff[1])
        else $error("output 0 not at idle level while stopped");
    AST_READ_ZERO: assert property (rd_setup && hit_cnt && !run |=> prdata == 32'h0)
        else $error("stopped counter did not read zero");
    AST_IRQ0: assert property (cnt_tick && cmp_mode && cnt_ff == buf_ff[0] |=> compare_match_irq_0)
        else $error("compare match 0 missed");
    AST_IRQ1: assert property (!(cnt_tick && cnt_ff == buf_ff[1]) |=> !compare_match_irq_1)
        else $error("spurious compare match 1");
    AST_BUF_HIDDEN: assert property (!(wr && (hit_ccr0 || hit_ccr1)) |=> $stable(buf_ff[0]) && $stable(buf_ff[1]))
        else $error("compare buffer changed without a write");
    AST_SW_TRIG: assert property (s_sw_start |=> s_started)
        else $error("software trigger did not start counting");
    AST_SW_IGNORE: assert property (wr && hit_ctl1 && !trig_mode && !armed_ff |=> !armed_ff)
        else $error("software trigger honoured outside trigger modes");
    AST_EVT_ONLY: assert property (run && mode == TEC_EVENT && !ext_evt && !slv_clr |=> $stable(cnt_ff))
        else $error("event count mode advanced without an edge");
    AST_DIV2: assert property (cnt_tick && !use_evt && ctl0_ff.clk_sel == 3'h1 && !wr |=> !cnt_tick)
        else $error("divide by two ticked twice in a row");
endmodule

// ===== tec_timer_ctrl_bench.sv
`timescale 1ns/10ps
module tec_timer_ctrl_bench
    import tec_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic        pready, pslverr, err, o1, o2;
    logic        tin0, tin1, subclk, mclr, irq0, irq1, tout0, tout1;
    int          n_errors, checks, p;
    logic [15:0] ev_exp [4] = '{16'hFFFF, 16'h0001, 16'h0001, 16'h0003};

    tec_timer_ctrl #(.CHANNEL(0)) tec_timer_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_input_0(tin0), .timer_input_1(tin1), .subclock(subclk), .master_clear(mclr),
        .sync_clear(), .compare_match_irq_0(irq0), .compare_match_irq_1(irq1),
        .timer_output_0(tout0), .timer_output_1(tout1));

    // ------------------------------------------------------------------
    // clock, watchdog, closing
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // the longest run is the divide-by-128 measurement, well inside this span
    initial begin
        repeat (60000) @(posedge pclk);
        n_errors++;
        conclude();
    end

    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) chk(32'h0, 32'h1);
        v       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(v, exp);
    endtask

    // cycles between two compare-match pulses; output 0 must toggle per match 0
    task automatic measure(input bit which);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while ((which ? irq1 : irq0) !== 1'b1 && n < 1000);
        o1 = tout0;
        p  = 0;
        do begin
            @(negedge pclk);
            p++;
        end while ((which ? irq1 : irq0) !== 1'b1 && p < 1000);
        o2 = tout0;
        if (!which) chk({31'h0, o1 ^ o2}, 32'h1);
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            tin0 <= 1'b1;
            repeat (8) @(posedge pclk);
            tin0 <= 1'b0;
            repeat (8) @(posedge pclk);
        end
        repeat (8) @(posedge pclk);
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        n_errors = 0;
        checks   = 0;
        presetn  = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 12'h000;
        pwdata   = 32'h0;
        tin0     = 1'b0;
        tin1     = 1'b0;
        subclk   = 1'b0;
        mclr     = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(TEC_CTL0_ADDR, 32'h0);
        rdchk(TEC_CTL1_ADDR, 32'h0);
        rdchk(TEC_CCR0_ADDR, 32'h0);
        rdchk(TEC_CCR1_ADDR, 32'h0);
        rdchk(TEC_CNT_ADDR, 32'h0);
        apb(1'b0, 12'h7FC, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("reset and map test done");

        apb(1'b1, TEC_CCR0_ADDR, 32'h2);
        apb(1'b1, TEC_CCR1_ADDR, 32'h1);
        apb(1'b1, TEC_OUTC_ADDR, 32'h1);
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, TEC_CTL0_ADDR, 32'h80 | k);
            measure(1'b0);
            chk(p, 3 << k);
            measure(1'b1);
            chk(p, 3 << k);
            apb(1'b1, TEC_CTL0_ADDR, 32'h80 | k);
            measure(1'b0);
            chk(p, 3 << k);
            apb(1'b1, TEC_CTL0_ADDR, 32'h0);
            rdchk(TEC_CNT_ADDR, 32'h0);
            chk({31'h0, tout0}, 32'h0);
            chk({31'h0, tout1}, 32'h0);
        end
        $display("interval test done");

        // event count mode with the event select bit left at zero, then the select bit set in interval mode
        apb(1'b1, TEC_CCR0_ADDR, 32'hFF);
        apb(1'b1, TEC_CTL1_ADDR, 32'h1);
        for (int e = 0; e < 4; e++) begin
            apb(1'b1, TEC_EVTE_ADDR, e << 2);
            apb(1'b1, TEC_CTL0_ADDR, 32'h80);
            pulses(2);
            rdchk(TEC_CNT_ADDR, {16'h0, ev_exp[e]});
            apb(1'b1, TEC_CTL0_ADDR, 32'h0);
        end
        apb(1'b1, TEC_CTL1_ADDR, 32'h20);
        apb(1'b1, TEC_EVTE_ADDR, 32'h4);
        apb(1'b1, TEC_CTL0_ADDR, 32'h80);
        pulses(2);
        rdchk(TEC_CNT_ADDR, 32'h1);
        apb(1'b1, TEC_CTL0_ADDR, 32'h0);
        $display("event test done");

        // trigger is ignored in event mode, honoured in one-shot mode
        apb(1'b1, TEC_EVTE_ADDR, 32'h0);
        apb(1'b1, TEC_CTL1_ADDR, 32'h1);
        apb(1'b1, TEC_CTL0_ADDR, 32'h80);
        apb(1'b1, TEC_CTL1_ADDR, 32'h41);
        repeat (5) @(posedge pclk);
        rdchk(TEC_CNT_ADDR, 32'hFFFF);
        apb(1'b1, TEC_CTL0_ADDR, 32'h0);
        apb(1'b1, TEC_CTL1_ADDR, 32'h3);
        apb(1'b1, TEC_CTL0_ADDR, 32'h80);
        repeat (10) @(posedge pclk);
        rdchk(TEC_CNT_ADDR, 32'hFFFF);
        apb(1'b1, TEC_CTL1_ADDR, 32'h43);
        repeat (3) @(posedge pclk);
        apb(1'b0, TEC_CNT_ADDR, 32'h0);
        chk({31'h0, v[15:0] !== 16'hFFFF}, 32'h1);
        $display("trigger test done");
        conclude();
    end
endmodule
